/* core/fup_ctrl.sv */
// flash lock, unlock, sector protect and status controller
// How it works
// RULE_01 - every reset puts the controller in the locked state.
// RULE_02 - unlock is 00H to command, page, 73H, 8CH, then the same page.
// RULE_03 - any write off the expected unlock step relocks the controller; the code moves to sector select on 5EH and ignores frequency writes.
// RULE_04 - the two frequency bytes form a 16-bit kHz value timing operations.
// RULE_05 - software loads a correct kHz value for 20kHz to 20MHz before use.
// RULE_06 - sector protection clears to zero on reset.
// RULE_07 - command 5EH steers the page address to the sector protect register.
// RULE_08 - sector protect writes only OR bits in and never clear them.
// RULE_09 - any other command deselects sector protect and restores page access.
// RULE_10 - one address reads status and writes the command register.
// RULE_11 - status shows 0,1,2,3 along the unlock path and 4 when selected.
// RULE_12 - status shows 08h, 10h or 20h during program, page or mass erase.
// RULE_13 - status bits seven and six read zero.
// RULE_14 - the read protect option blocks debug and bypass reads of flash.
// RULE_15 - the information area holds a zero-padded 20-char part code.
// RULE_16 - page select bit 7 overlays the information area at FE00H.
// RULE_17 - after an operation ends, status shows the state that then applies.
module fup_ctrl
    import fup_pkg::*;
#(
    parameter logic [8*FUP_PART_LEN-1:0] PART_CODE = {"FUPCORE0", 96'h0}
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire fup_req_t i_req,
    output logic [7:0] o_rdata,
    input wire logic i_prog_wr,
    input wire logic [15:0] i_prog_addr,
    input wire logic [7:0] i_prog_data,
    input wire logic i_ext_rd,
    input wire logic [15:0] i_ext_addr,
    input wire logic [7:0] i_flash_rdata,
    input wire logic i_read_protect,
    output logic o_ext_block,
    output logic [7:0] o_ext_rdata,
    output logic o_info_sel,
    output logic o_cmd_valid,
    output fup_cmd_t o_cmd,
    output logic [7:0] o_sect_prot
);
    fup_state_t st_reg, st_next;
    fup_op_t op_reg, op_next;
    logic [7:0] page_reg, page_next;
    logic [7:0] sect_reg, sect_next;
    logic [15:0] freq_reg, freq_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [31:0] khz_reg, khz_next;
    logic [7:0] rdata_reg, rdata_next;
    logic cmd_v_reg, cmd_v_next;
    fup_cmd_t cmd_reg, cmd_next;
    logic ext_info_reg, ext_blk_reg;
    logic [7:0] ext_flash_reg;
    logic [7:0] rom_data;
    logic wr_cmd, wr_page;
    logic [2:0] sect_idx;
    logic [5:0] stat_field;

    assign wr_cmd = i_req.wr && i_req.addr == FUP_ADDR_CMD_STAT; // see RULE_10
    assign wr_page = i_req.wr && i_req.addr == FUP_ADDR_PAGE_SP;
    assign sect_idx = page_reg[2:0];

    function automatic logic [5:0] stat_of(fup_state_t s, fup_op_t op);
        case (s)
            FUP_FIRST: stat_of = FUP_ST_FIRST; // see RULE_11
            FUP_SECOND: stat_of = FUP_ST_SECOND;
            FUP_UNLOCKED: stat_of = FUP_ST_UNLOCKED;
            FUP_SECT: stat_of = FUP_ST_SECT_SEL;
            FUP_BUSY: begin
                // see RULE_12
                if (op == FUP_OP_PROG) stat_of = FUP_ST_PROG;
                else if (op == FUP_OP_PERASE) stat_of = FUP_ST_PERASE;
                else stat_of = FUP_ST_MERASE;
            end
            default: stat_of = FUP_ST_LOCKED;
        endcase
    endfunction

    assign stat_field = stat_of(st_reg, op_reg);

    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        page_next = page_reg;
        sect_next = sect_reg;
        freq_next = freq_reg;
        cnt_next = cnt_reg;
        khz_next = khz_reg;
        cmd_v_next = 1'b0;
        cmd_next = cmd_reg;
        rdata_next = rdata_reg;
        if (i_req.rd) begin
            if (i_req.addr == FUP_ADDR_CMD_STAT) begin
                rdata_next = {2'b00, stat_field}; // see RULE_13
            end else if (i_req.addr == FUP_ADDR_PAGE_SP) begin
                rdata_next = (st_reg == FUP_SECT) ? sect_reg : page_reg;
            end else if (i_req.addr == FUP_ADDR_FREQ_HI) begin
                rdata_next = freq_reg[15:8];
            end else if (i_req.addr == FUP_ADDR_FREQ_LO) begin
                rdata_next = freq_reg[7:0];
            end else begin
                rdata_next = 8'h00;
            end
        end
        // see RULE_04
        if (i_req.wr && i_req.addr == FUP_ADDR_FREQ_HI) begin
            freq_next[15:8] = i_req.wdata;
        end
        if (i_req.wr && i_req.addr == FUP_ADDR_FREQ_LO) begin
            freq_next[7:0] = i_req.wdata;
        end
        if (st_reg == FUP_BUSY) begin
            // one tick per system clock; every freq cycles is 1 ms
            if (khz_reg + 32'd1 >= 32'(freq_reg)) begin
                khz_next = '0;
                cnt_next = cnt_reg - 32'd1;
            end else begin
                khz_next = khz_reg + 32'd1;
            end
            if (cnt_reg == 32'd0) begin
                st_next = FUP_UNLOCKED; // see RULE_17
                op_next = FUP_OP_NONE;
            end
        end else if (wr_cmd) begin
            // see RULE_09
            if (i_req.wdata == FUP_CMD_SECT_PROT) begin
                st_next = FUP_SECT; // see RULE_07
            end else if (st_reg == FUP_PAGE_OK &&
                         i_req.wdata == FUP_CMD_UNLOCK1) begin
                st_next = FUP_FIRST; // see RULE_02
            end else if (st_reg == FUP_FIRST &&
                         i_req.wdata == FUP_CMD_UNLOCK2) begin
                st_next = FUP_SECOND;
            end else if (st_reg == FUP_UNLOCKED &&
                         (i_req.wdata == FUP_CMD_PAGE_ERASE ||
                          i_req.wdata == FUP_CMD_MASS_ERASE) &&
                         !sect_reg[sect_idx]) begin
                st_next = FUP_BUSY;
                op_next = (i_req.wdata == FUP_CMD_MASS_ERASE) ?
                          FUP_OP_MERASE : FUP_OP_PERASE;
                cnt_next = FUP_ERASE_TICKS;
                khz_next = '0;
                cmd_v_next = 1'b1;
                cmd_next = '{op: op_next, page: page_reg,
                             addr: 16'h0000, data: 8'h00};
            end else if (i_req.wdata == FUP_CMD_RESET) begin
                st_next = FUP_LOCKED; // reset step opens the sequence
            end else begin
                st_next = FUP_LOCKED; // see RULE_03
            end
        end else if (wr_page) begin
            if (st_reg == FUP_SECT) begin
                sect_next = sect_reg | i_req.wdata; // see RULE_08
            end else begin
                page_next = i_req.wdata;
                if (st_reg == FUP_LOCKED) begin
                    st_next = FUP_PAGE_OK;
                end else if (st_reg == FUP_SECOND &&
                             i_req.wdata == page_reg) begin
                    st_next = FUP_UNLOCKED; // see RULE_02
                end else begin
                    st_next = FUP_LOCKED; // see RULE_03
                end
            end
        end else if (i_prog_wr && st_reg == FUP_UNLOCKED &&
                     !sect_reg[sect_idx]) begin
            st_next = FUP_BUSY;
            op_next = FUP_OP_PROG;
            cnt_next = FUP_PROG_TICKS / 32'd1000 + 32'd1;
            khz_next = '0;
            cmd_v_next = 1'b1;
            cmd_next = '{op: FUP_OP_PROG, page: page_reg,
                         addr: i_prog_addr, data: i_prog_data};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= FUP_LOCKED; // see RULE_01
            op_reg <= FUP_OP_NONE;
            page_reg <= FUP_PAGE_RST;
            sect_reg <= FUP_SECT_RST; // see RULE_06
            freq_reg <= FUP_FREQ_RST;
            cnt_reg <= '0;
            khz_reg <= '0;
            rdata_reg <= FUP_STAT_RST;
            cmd_v_reg <= 1'b0;
            cmd_reg <= '0;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            page_reg <= page_next;
            sect_reg <= sect_next;
            freq_reg <= freq_next;
            cnt_reg <= cnt_next;
            khz_reg <= khz_next;
            rdata_reg <= rdata_next;
            cmd_v_reg <= cmd_v_next;
            cmd_reg <= cmd_next;
        end
    end

    // external (debug / bypass) read path with information overlay
    logic ext_info_hit;
    logic [15:0] part_off;
    assign ext_info_hit = page_reg[FUP_INFO_BIT] &&
                          i_ext_addr >= FUP_INFO_BASE; // see RULE_16
    assign part_off = i_ext_addr - FUP_PART_BASE;

    fup_part_rom #(.LEN(FUP_PART_LEN)) u_rom (
        .i_clk(i_clk),
        .i_idx((i_ext_addr >= FUP_PART_BASE &&
                part_off < 16'(FUP_PART_LEN)) ? part_off[4:0] : 5'h1f),
        .i_code(PART_CODE),
        .o_data(rom_data)
    ); // see RULE_15

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_info_reg <= 1'b0;
            ext_blk_reg <= 1'b0;
            ext_flash_reg <= 8'h00;
        end else begin
            ext_info_reg <= i_ext_rd && ext_info_hit;
            // see RULE_14
            ext_blk_reg <= i_ext_rd && i_read_protect && !ext_info_hit;
            ext_flash_reg <= (i_ext_rd && !i_read_protect) ?
                             i_flash_rdata : 8'h00;
        end
    end

    assign o_ext_rdata = ext_info_reg ? rom_data :
                         (ext_blk_reg ? 8'hff : ext_flash_reg);
    assign o_ext_block = ext_blk_reg;
    assign o_info_sel = page_reg[FUP_INFO_BIT];
    assign o_rdata = rdata_reg;
    assign o_cmd_valid = cmd_v_reg;
    assign o_cmd = cmd_reg;
    assign o_sect_prot = sect_reg;

    relock_wrong_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_cmd && st_reg == FUP_FIRST && i_req.wdata != FUP_CMD_UNLOCK2 &&
        i_req.wdata != FUP_CMD_SECT_PROT |=> st_reg == FUP_LOCKED)
        else $error("bad command did not relock"); // see RULE_03
    unlock_path_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_page && st_reg == FUP_SECOND && i_req.wdata == page_reg
        |=> st_reg == FUP_UNLOCKED && stat_field == FUP_ST_UNLOCKED)
        else $error("unlock did not complete"); // see RULE_02
    reset_lock_a: assert property (@(posedge i_clk)
        i_rst |=> st_reg == FUP_LOCKED && sect_reg == 8'h00)
        else $error("reset left state"); // see RULE_01
    sect_or_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (sect_reg & $past(sect_reg)) == $past(sect_reg))
        else $error("protect bit cleared"); // see RULE_08
    sect_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_cmd && st_reg != FUP_BUSY && i_req.wdata == FUP_CMD_SECT_PROT
        |=> stat_field == FUP_ST_SECT_SEL)
        else $error("select not shown"); // see RULE_07
    sect_desel_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_cmd && st_reg == FUP_SECT && i_req.wdata != FUP_CMD_SECT_PROT
        |=> st_reg != FUP_SECT)
        else $error("select not dropped"); // see RULE_09
    stat_top_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_req.rd && i_req.addr == FUP_ADDR_CMD_STAT)
        |-> o_rdata[7:6] == 2'b00)
        else $error("reserved status bits set"); // see RULE_13
    busy_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg == FUP_BUSY && op_reg == FUP_OP_PROG
        |-> stat_field[5:3] == 3'b001)
        else $error("program code wrong"); // see RULE_12
    busy_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg == FUP_BUSY && cnt_reg == 32'd0
        |=> stat_field == FUP_ST_UNLOCKED)
        else $error("status stuck busy"); // see RULE_17
    protect_blk_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ext_rd && i_read_protect && !ext_info_hit |=> o_ext_rdata == 8'hff)
        else $error("protected read leaked"); // see RULE_14
endmodule

/* core/fup_part_rom.sv */
// part code lookup with registered read data
module fup_part_rom
    import fup_pkg::*;
#(
    parameter int LEN = FUP_PART_LEN
) (
    input wire logic i_clk,
    input wire logic [4:0] i_idx,
    input wire logic [8*LEN-1:0] i_code,
    output logic [7:0] o_data
);
    // index 31 is the past-end code, so at most 31 characters fit
    if (LEN < 1 || LEN > 31) begin : g_len_check
        $error("fup_part_rom: bad LEN");
    end

    logic [7:0] data_next;

    always_comb begin
        data_next = 8'h00;
        // left-justified: character 0 sits in the top byte; past end is zero
        if (32'(i_idx) < LEN) begin
            data_next = i_code[8*(LEN-1-32'(i_idx)) +: 8];
        end
    end

    always_ff @(posedge i_clk) begin
        o_data <= data_next;
    end
endmodule

/* core/fup_pkg.sv */
// shared constants and types for the flash unlock and protect controller
package fup_pkg;

    // register file addresses (12-bit)
    localparam logic [11:0] FUP_ADDR_CMD_STAT = 12'hff8;
    localparam logic [11:0] FUP_ADDR_PAGE_SP = 12'hff9;
    localparam logic [11:0] FUP_ADDR_FREQ_HI = 12'hffa;
    localparam logic [11:0] FUP_ADDR_FREQ_LO = 12'hffb;

    // command codes written to the command register
    localparam logic [7:0] FUP_CMD_RESET = 8'h00;
    localparam logic [7:0] FUP_CMD_UNLOCK1 = 8'h73;
    localparam logic [7:0] FUP_CMD_UNLOCK2 = 8'h8c;
    localparam logic [7:0] FUP_CMD_SECT_PROT = 8'h5e;
    localparam logic [7:0] FUP_CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] FUP_CMD_PAGE_ERASE = 8'h95;

    // status field encodings
    localparam logic [5:0] FUP_ST_LOCKED = 6'h00;
    localparam logic [5:0] FUP_ST_FIRST = 6'h01;
    localparam logic [5:0] FUP_ST_SECOND = 6'h02;
    localparam logic [5:0] FUP_ST_UNLOCKED = 6'h03;
    localparam logic [5:0] FUP_ST_SECT_SEL = 6'h04;
    localparam logic [5:0] FUP_ST_PROG = 6'h08;
    localparam logic [5:0] FUP_ST_PERASE = 6'h10;
    localparam logic [5:0] FUP_ST_MERASE = 6'h20;

    // reset values
    localparam logic [7:0] FUP_STAT_RST = 8'h00;
    localparam logic [7:0] FUP_SECT_RST = 8'h00;
    localparam logic [7:0] FUP_PAGE_RST = 8'h00;
    localparam logic [15:0] FUP_FREQ_RST = 16'h0000;

    // page select bit that overlays the information area
    localparam int FUP_INFO_BIT = 7;
    localparam logic [15:0] FUP_INFO_BASE = 16'hfe00;
    localparam logic [15:0] FUP_PART_BASE = 16'hfe40;
    localparam int FUP_PART_LEN = 20;

    // operation times at the kHz rate: program 40 us rounds up to 1 ms, erase counts 10000 ms
    localparam int FUP_PROG_US = 40;
    localparam int FUP_ERASE_MS = 10;
    localparam logic [31:0] FUP_PROG_TICKS = 32'(FUP_PROG_US);
    localparam logic [31:0] FUP_ERASE_TICKS = 32'(FUP_ERASE_MS * 1000);

    typedef enum logic [2:0] {
        FUP_LOCKED = 3'b000,
        FUP_PAGE_OK = 3'b001,
        FUP_FIRST = 3'b011,
        FUP_SECOND = 3'b010,
        FUP_UNLOCKED = 3'b110,
        FUP_BUSY = 3'b111,
        FUP_SECT = 3'b100
    } fup_state_t;

    typedef enum logic [1:0] {
        FUP_OP_NONE = 2'b00,
        FUP_OP_PROG = 2'b01,
        FUP_OP_PERASE = 2'b10,
        FUP_OP_MERASE = 2'b11
    } fup_op_t;

    // register bus request from the processor
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } fup_req_t;

    // flash array command
    typedef struct packed {
        fup_op_t op;
        logic [7:0] page;
        logic [15:0] addr;
        logic [7:0] data;
    } fup_cmd_t;

endpackage

/* sim/fup_ctrl_tb.sv */
// self-checking bench for the flash unlock and protect controller
module fup_ctrl_tb
    import fup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // arbitrary part code, left-justified and zero padded
    localparam logic [159:0] CODE = {"FUPTEST", 104'h0};
    logic clk, rst, prog_wr, ext_rd, rprot, ext_block, info_sel, cmd_valid;
    logic [7:0] rdata, flash_rdata, ext_rdata, sect, p;
    logic [15:0] ext_addr, a, r;
    logic [11:0] ba [4];
    logic [7:0] bd [4];
    int bn [4] = '{2, 3, 3, 4};
    fup_req_t req;
    fup_cmd_t cmd, pc;
    int fails = 0;
    int samples_checked = 0;
    int m_st, m_sect, m_page, n1, n3;

    fup_ctrl #(.PART_CODE(CODE)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_req(req), .o_rdata(rdata),
        .i_prog_wr(prog_wr), .i_prog_addr(pc.addr), .i_prog_data(pc.data),
        .i_ext_rd(ext_rd), .i_ext_addr(ext_addr), .i_flash_rdata(flash_rdata),
        .i_read_protect(rprot), .o_ext_block(ext_block),
        .o_ext_rdata(ext_rdata), .o_info_sel(info_sel),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_sect_prot(sect));
    fup_flash_model u_flash (
        .i_clk(clk), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_addr(ext_addr), .o_rdata(flash_rdata));

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        close_out();
    end

    task automatic chk(string n, logic [39:0] e, logic [39:0] s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    // step 7 stands for the armed state, which still reads as locked
    function automatic void m_wr(logic [11:0] ad, logic [7:0] v);
        // frequency bytes leave the sequence alone
        if (ad != FUP_ADDR_CMD_STAT && ad != FUP_ADDR_PAGE_SP) return;
        if (ad == FUP_ADDR_CMD_STAT) begin
            if (v == FUP_CMD_SECT_PROT) m_st = 4;
            else if (v == FUP_CMD_UNLOCK1 && m_st == 7) m_st = 1;
            else if (v == FUP_CMD_UNLOCK2 && m_st == 1) m_st = 2;
            else if (m_st == 3 && !m_sect[m_page[2:0]] &&
                     (v == FUP_CMD_PAGE_ERASE || v == FUP_CMD_MASS_ERASE))
                m_st = 3;
            else m_st = 0;
        end else if (m_st == 4) begin
            m_sect = m_sect | int'(v);
        end else if (m_st == 0) begin
            m_st = 7;
            m_page = int'(v);
        end else begin
            m_st = (m_st == 2 && int'(v) == m_page) ? 3 : 0;
        end
    endfunction

    task automatic bus(logic w, logic [11:0] ad, logic [7:0] v);
        req = '{w, !w, ad, v};
        @(posedge clk);
        #1;
        if (w) m_wr(ad, v);
    endtask

    task automatic idle();
        req = '0;
        @(posedge clk);
        #1;
    endtask

    task automatic st_chk();
        bus(0, FUP_ADDR_CMD_STAT, 8'h00);
        chk("status", (m_st == 7) ? 0 : m_st, rdata);
    endtask

    function automatic void rnd();
        r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    endfunction

    task automatic unlock(logic [7:0] pg, int n, bit show);
        logic [7:0] sd [5];
        sd = '{FUP_CMD_RESET, pg, FUP_CMD_UNLOCK1, FUP_CMD_UNLOCK2, pg};
        for (int i = 0; i < n; i++) begin
            bus(1, (i == 1 || i == 4) ? FUP_ADDR_PAGE_SP : 12'hff8, sd[i]);
            if (show) st_chk();
        end
    endtask

    // strobe stays up between back to back reads; last drops it
    task automatic xrd(logic [15:0] ad, bit last);
        ext_addr = ad;
        ext_rd = 1;
        @(posedge clk);
        #1;
        if (last) ext_rd = 0;
    endtask

    task automatic prog();
        prog_wr = 1;
        @(posedge clk);
        #1;
        prog_wr = 0;
    endtask

    task automatic do_reset();
        rst = 1;
        repeat (2) @(posedge clk);
        #1;
        rst = 0;
        m_st = 0;
        m_sect = 0;
        idle();
    endtask

    // runs one operation on page pg and returns its busy time in polls
    task automatic op(int k, logic [7:0] pg, output int n);
        logic [7:0] ec [3];
        ec = '{8'h00, FUP_CMD_PAGE_ERASE, FUP_CMD_MASS_ERASE};
        pc.op = fup_op_t'(k + 1);
        pc.page = pg;
        unlock(pg, 5, 0);
        idle();
        if (k == 0) prog();
        else bus(1, FUP_ADDR_CMD_STAT, ec[k]);
        chk("start", 1, cmd_valid);
        chk("cmd", k ? pc[33:24] : pc, k ? cmd[33:24] : cmd);
        bus(0, FUP_ADDR_CMD_STAT, 8'h00);
        chk("busy", {2'b00, 3'(3'b001 << k)}, rdata[7:3]);
        n = 0;
        while (rdata[5:3] !== 3'b000 && n < 30000) begin
            bus(0, FUP_ADDR_CMD_STAT, 8'h00);
            n++;
        end
        chk("done", 0, rdata[5:3]);
        bus(1, FUP_ADDR_CMD_STAT, FUP_CMD_RESET);
        idle();
    endtask

    initial begin
        rst = 1;
        req = '0;
        prog_wr = 0;
        pc = '0;
        ext_rd = 0;
        ext_addr = '0;
        rprot = 0;
        r = 16'd23457;
        #1;
        do_reset();
        chk("sect", 0, sect);
        chk("info", 0, info_sel);
        st_chk();
        prog();
        chk("start", 0, cmd_valid);
        rnd();
        p = {1'b0, r[6:0]};
        unlock(p, 5, 1);
        ba = '{12'hff8, 12'hff8, 12'hff9, 12'hff9};
        bd = '{FUP_CMD_UNLOCK2, FUP_CMD_UNLOCK1, p, p ^ 8'h01};
        for (int j = 0; j < 4; j++) begin
            unlock(p, bn[j], 0);
            bus(1, ba[j], bd[j]);
            st_chk();
        end
        rnd();
        a = {p[6:0], r[8:0]};
        pc.addr = a;
        pc.data = r[15:8];
        bus(1, FUP_ADDR_FREQ_HI, 8'h00);
        bus(1, FUP_ADDR_FREQ_LO, 8'h01);
        op(0, p, n1);
        xrd(a, 1);
        chk("flash", {1'b0, pc.data}, {ext_block, ext_rdata});
        op(1, p, n3);
        xrd(a, 1);
        chk("erased", 8'hff, ext_rdata);
        op(2, p, n3);
        bus(1, FUP_ADDR_FREQ_LO, 8'h03);
        op(0, p, n3);
        chk("scale", 1, n3 > n1);
        rprot = 1;
        xrd(a, 1);
        chk("blocked", 9'h1ff, {ext_block, ext_rdata});
        rprot = 0;
        bus(1, FUP_ADDR_CMD_STAT, FUP_CMD_SECT_PROT);
        st_chk();
        for (int j = 0; j < 3; j++) begin
            rnd();
            bus(1, FUP_ADDR_PAGE_SP, j == 2 ? 8'h00 : r[7:0] | 8'h01);
        end
        idle();
        chk("sect", m_sect, sect);
        bus(1, FUP_ADDR_CMD_STAT, FUP_CMD_RESET);
        bus(1, FUP_ADDR_PAGE_SP, 8'h80);
        idle();
        chk("sect", m_sect, sect);
        chk("info", 1, info_sel);
        for (int i = 0; i < 8; i++) begin
            xrd(FUP_PART_BASE + 16'(i), i == 7);
            chk("part", CODE[159 - 8 * i -: 8], ext_rdata);
        end
        // fall back to sector 0, whose protect bit is always set above
        p = m_sect[r[2:0]] ? ({5'h00, r[2:0]} | 8'h08) : 8'h08;
        unlock(p, 5, 1);
        prog();
        chk("start", 0, cmd_valid);
        do_reset();
        chk("sect", 0, sect);
        st_chk();
        close_out();
    end
endmodule

/* sim/fup_flash_model.sv */
// behavioural flash array standing behind the controller
module fup_flash_model
    import fup_pkg::*;
#(
    parameter int PAGE_BITS = 9
) (
    input wire logic i_clk,
    input wire logic i_cmd_valid,
    input wire fup_cmd_t i_cmd,
    input wire logic [15:0] i_addr,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [65536];

    // programming only clears bits; erase brings bytes back to ff
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hff;
        end
    end
    assign o_rdata = mem[i_addr];
    always @(posedge i_clk) begin
        if (i_cmd_valid) begin
            for (int i = 0; i < 65536; i++) begin
                if (i_cmd.op == FUP_OP_MERASE ||
                        (i_cmd.op == FUP_OP_PERASE &&
                        (i >> PAGE_BITS) == int'(i_cmd.page[6:0]))) begin
                    mem[i] = 8'hff;
                end
            end
            if (i_cmd.op == FUP_OP_PROG) begin
                mem[i_cmd.addr] = mem[i_cmd.addr] & i_cmd.data;
            end
        end
    end
endmodule
